// [hw/serial_in_parallel_out_latch.v]
// Functional notes
// [R01] eight-stage shift register feeds eight-bit storage register outputs
// [R02] shift and storage registers each have own clock and overriding clear
// [R03] serial output from shift register allows chaining further devices
// [R04] both clocks act on rising edge only
// [R05] common clocks: storage takes shift contents from before the edge
// [R06] shift clear low forces all shift stages to zero
// [R07] shift rising edge: stage one takes serial input, others shift along
// [R08] shift clock falling edge leaves shift register unchanged
// [R09] storage clear low forces storage register to zero
// [R10] storage rising edge loads all eight shift stages in parallel
// [R11] storage clock falling edge leaves storage register unchanged
// [R12] cascade output shows last shift stage, bits leave in entry order
// [R13] controller sets data before shift edge, then pulses storage clock
`timescale 1ns/100ps
`include "sipo_latch_regs.vh"

module serial_in_parallel_out_latch #(
    parameter WIDTH = `SIPO_WIDTH,
    parameter FIFO_DEPTH = `SIPO_FIFO_DEPTH,
    parameter FIFO_AW = `SIPO_FIFO_AW
) (
    input wire clk_i,
    input wire resetn_i,
    input wire clk_en_i,
    input wire serial_data_in_i,
    input wire shift_clock_i,
    input wire shift_clear_n_i,
    input wire storage_clock_i,
    input wire storage_clear_n_i,
    output wire [WIDTH-1:0] parallel_out_o,
    output wire cascade_serial_out_o,
    output wire [WIDTH-1:0] word_data_o,
    output wire word_valid_o,
    input wire word_ready_i,
    output wire capture_ready_o,
    output wire word_lost_o,
    output wire [FIFO_AW:0] fifo_level_o
);

    // ****************************************
    // pin synchronisers
    // ****************************************
    // three stages per pin; a pin level is accepted only once stages two
    // and three agree, which rejects a single-sample glitch at the cost
    // of one more cycle of latency
    function [`SIPO_PIN_COUNT-1:0] agree_filter;
        input [`SIPO_PIN_COUNT-1:0] second;
        input [`SIPO_PIN_COUNT-1:0] third;
        input [`SIPO_PIN_COUNT-1:0] held;
        begin
            agree_filter = (second & third) | (held & (second | third));
        end
    endfunction

    wire [`SIPO_PIN_COUNT-1:0] pins_raw;
    reg [`SIPO_PIN_COUNT-1:0] sync_1;
    reg [`SIPO_PIN_COUNT-1:0] sync_2;
    reg [`SIPO_PIN_COUNT-1:0] sync_3;
    reg [`SIPO_PIN_COUNT-1:0] pins;
    wire [`SIPO_PIN_COUNT-1:0] next_pins;

    assign pins_raw = {storage_clear_n_i, storage_clock_i, shift_clear_n_i,
                       shift_clock_i, serial_data_in_i};
    assign next_pins = agree_filter(sync_2, sync_3, pins);

    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sync_1 <= `SIPO_PIN_RESET;
            sync_2 <= `SIPO_PIN_RESET;
            sync_3 <= `SIPO_PIN_RESET;
            pins <= `SIPO_PIN_RESET;
        end else if (clk_en_i) begin
            sync_1 <= pins_raw;
            sync_2 <= sync_1;
            sync_3 <= sync_2;
            pins <= next_pins;
        end
    end

    // ****************************************
    // edge detection
    // ****************************************
    wire shift_level;
    wire store_level;
    wire shift_clear_n;
    wire store_clear_n;
    wire serial_bit;
    wire shift_rise;
    wire store_rise;

    assign serial_bit = pins[`SIPO_PIN_DATA];
    assign shift_level = pins[`SIPO_PIN_SHIFT_CLK];
    assign store_level = pins[`SIPO_PIN_STORE_CLK];
    assign shift_clear_n = pins[`SIPO_PIN_SHIFT_CLR];
    assign store_clear_n = pins[`SIPO_PIN_STORE_CLR];

    // only a low-to-high change is an edge; falling changes are ignored,
    // so a clock pin parked high between frames never moves any state
    function rising;
        input prev;
        input now;
        begin
            rising = ~prev & now;
        end
    endfunction

    // both clock pins share one detector so their latency stays equal,
    // which is what keeps tied clocks one edge apart
    assign shift_rise = rising(shift_level,
                               next_pins[`SIPO_PIN_SHIFT_CLK]); // R04 R08
    assign store_rise = rising(store_level,
                               next_pins[`SIPO_PIN_STORE_CLK]); // R04 R11

    // ****************************************
    // shift register
    // ****************************************
    // the serial bit used is the one accepted in the same cycle as the edge,
    // so data set up ahead of the clock pin is taken
    reg [WIDTH-1:0] shift_reg;
    reg [WIDTH-1:0] next_shift;
    wire next_serial_bit;

    assign next_serial_bit = next_pins[`SIPO_PIN_DATA];

    always @* begin
        next_shift = shift_reg;
        if (!next_pins[`SIPO_PIN_SHIFT_CLR]) begin
            next_shift = {WIDTH{1'b0}}; // R02 R06
        end else if (shift_rise) begin
            next_shift = {shift_reg[WIDTH-2:0], next_serial_bit}; // R07 R13
        end
    end

    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            shift_reg <= `SIPO_SHIFT_RESET;
        end else if (clk_en_i) begin
            shift_reg <= next_shift; // R01
        end
    end

    // cascade taps the last stage, so a chained part sees bits in entry order
    assign cascade_serial_out_o = shift_reg[WIDTH-1]; // R03 R12

    // ****************************************
    // storage register
    // ****************************************
    reg [WIDTH-1:0] store_reg;
    reg [WIDTH-1:0] next_store;
    wire store_load;

    assign store_load = store_rise & next_pins[`SIPO_PIN_STORE_CLR];

    // shift_reg is read before its own update lands, so with both clock pins
    // tied the storage register holds the word from one edge earlier
    always @* begin
        next_store = store_reg;
        if (!next_pins[`SIPO_PIN_STORE_CLR]) begin
            next_store = {WIDTH{1'b0}}; // R02 R09
        end else if (store_load) begin
            next_store = shift_reg; // R05 R10
        end
    end

    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            store_reg <= `SIPO_STORE_RESET;
        end else if (clk_en_i) begin
            store_reg <= next_store;
        end
    end

    assign parallel_out_o = store_reg; // R01

    // ****************************************
    // captured word stream
    // ****************************************
    // every storage load is also queued for on-chip consumers; the pins
    // cannot be held off, so a load against a full fifo is dropped and
    // flagged rather than stalling the parallel outputs
    wire fifo_wr_ready;
    reg lost;
    reg next_lost;

    word_fifo #(
        .WIDTH(WIDTH),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_fifo (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .clk_en_i(clk_en_i),
        .wr_data_i(shift_reg),
        .wr_valid_i(store_load),
        .wr_ready_o(fifo_wr_ready),
        .rd_data_o(word_data_o),
        .rd_valid_o(word_valid_o),
        .rd_ready_i(word_ready_i),
        .level_o(fifo_level_o)
    );

    // a held clear also masks store_load, so no drop can share its cycle and a
    // loss is never hidden by the clear that software uses to acknowledge it
    always @* begin
        next_lost = lost;
        if (store_load && !fifo_wr_ready) begin
            next_lost = 1'b1;
        end else if (!next_pins[`SIPO_PIN_STORE_CLR]) begin
            next_lost = 1'b0;
        end
    end

    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            lost <= 1'b0;
        end else if (clk_en_i) begin
            lost <= next_lost;
        end
    end

    assign capture_ready_o = fifo_wr_ready;
    assign word_lost_o = lost;

endmodule // serial_in_parallel_out_latch

// [hw/sipo_latch_regs.vh]
`ifndef SIPO_LATCH_REGS_VH
`define SIPO_LATCH_REGS_VH

// ****************************************
// widths and depths
// ****************************************
`define SIPO_WIDTH 8
`define SIPO_FIFO_DEPTH 32
`define SIPO_FIFO_AW 5

// ****************************************
// pin vector layout after synchronising
// ****************************************
`define SIPO_PIN_COUNT 5
`define SIPO_PIN_DATA 0
`define SIPO_PIN_SHIFT_CLK 1
`define SIPO_PIN_SHIFT_CLR 2
`define SIPO_PIN_STORE_CLK 3
`define SIPO_PIN_STORE_CLR 4

// ****************************************
// reset values
// ****************************************
// clocks start high so a pin already high gives no edge at release,
// clears start asserted
`define SIPO_PIN_RESET 5'h0a
`define SIPO_SHIFT_RESET 8'h00
`define SIPO_STORE_RESET 8'h00

`endif

// [hw/word_fifo.v]
`timescale 1ns/100ps
`include "sipo_latch_regs.vh"

// ****************************************
// synchronous fifo with valid and ready on both sides
// ****************************************
module word_fifo #(
    parameter WIDTH = `SIPO_WIDTH,
    parameter DEPTH = `SIPO_FIFO_DEPTH,
    parameter AW = `SIPO_FIFO_AW
) (
    input wire clk_i,
    input wire resetn_i,
    input wire clk_en_i,
    input wire [WIDTH-1:0] wr_data_i,
    input wire wr_valid_i,
    output wire wr_ready_o,
    output wire [WIDTH-1:0] rd_data_o,
    output wire rd_valid_o,
    input wire rd_ready_i,
    output wire [AW:0] level_o
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    wire do_wr;
    wire do_rd;

    assign wr_ready_o = (count != DEPTH[AW:0]);
    assign rd_valid_o = (count != {(AW+1){1'b0}});
    assign do_wr = wr_valid_i & wr_ready_o & clk_en_i;
    assign do_rd = rd_ready_i & rd_valid_o & clk_en_i;
    assign rd_data_o = mem[rd_ptr];
    assign level_o = count;

    // memory carries no reset so it maps onto ram
    always @(posedge clk_i) begin
        if (do_wr) begin
            mem[wr_ptr] <= wr_data_i;
        end
    end

    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else begin
            if (do_wr) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_rd) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (do_wr && !do_rd) begin
                count <= count + 1'b1;
            end else if (do_rd && !do_wr) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule // word_fifo

// [verif/serial_in_parallel_out_latch_bench.sv]
`timescale 1ns/100ps
// ****
// corner words, tied clocks, clears, fifo fill
// ****
module serial_in_parallel_out_latch_bench;
    logic clk_i, resetn_i, word_ready_i;
    logic clk_en_i = 1'b1;
    wire serial_data_in_i, shift_clock_i, shift_clear_n_i, storage_clock_i;
    wire storage_clear_n_i, cascade_serial_out_o, word_valid_o;
    wire capture_ready_o, word_lost_o;
    wire [7:0] parallel_out_o, word_data_o;
    wire [5:0] fifo_level_o;
    int miscompares = 0;
    int checked = 0;
    logic [31:0] rng = 32'h2b;
    logic [7:0] shadow = 8'h00;
    logic [7:0] q[$];
    sipo_controller ctl (.clk_i, .data_o(serial_data_in_i),
        .sh_clk_o(shift_clock_i), .sh_clr_n_o(shift_clear_n_i),
        .st_clk_o(storage_clock_i), .st_clr_n_o(storage_clear_n_i));
    serial_in_parallel_out_latch uut (.clk_i, .resetn_i, .clk_en_i,
        .serial_data_in_i, .shift_clock_i, .shift_clear_n_i,
        .storage_clock_i, .storage_clear_n_i, .parallel_out_o,
        .cascade_serial_out_o, .word_data_o, .word_valid_o, .word_ready_i,
        .capture_ready_o, .word_lost_o, .fifo_level_o);
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic [7:0] shifted(logic [7:0] sr, logic b);
        return {sr[6:0], b};
    endfunction
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic loaded(input logic [7:0] w);
        if (q.size() < 32) q.push_back(w);
        cmp(parallel_out_o, w);
    endtask
    task automatic send(input logic b, input logic tie);
        logic [7:0] pre;
        pre = shadow;
        ctl.shift_bit(b, tie);
        shadow = shifted(shadow, b);
        cmp({7'h00, cascade_serial_out_o}, {7'h00, shadow[7]});
        if (tie) loaded(pre);
    endtask
    task automatic send_word(input logic [7:0] w);
        for (int i = 7; i >= 0; i--) send(w[i], 1'b0);
        ctl.store();
        loaded(shadow);
    endtask
    task automatic drain;
        while (q.size() > 0) begin
            rng = xs(rng);
            repeat (rng[1:0]) @(negedge clk_i);
            cmp({7'h00, word_valid_o}, 8'h01);
            cmp(word_data_o, q.pop_front());
            word_ready_i = 1'b1;
            @(negedge clk_i);
            word_ready_i = 1'b0;
            @(negedge clk_i);
        end
        cmp({2'h0, fifo_level_o}, 8'h00);
    endtask
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    initial begin
        repeat (5000) @(posedge clk_i);
        miscompares++;
        print_verdict;
    end
    initial begin
        resetn_i = 1'b0;
        word_ready_i = 1'b0;
        repeat (10) @(negedge clk_i);
        resetn_i = 1'b1;
        repeat (6) @(negedge clk_i);
        cmp(parallel_out_o, 8'h00);
        send_word(8'h80);
        send_word(8'h01);
        drain;
        $display("words done");
        for (int i = 0; i < 8; i++) send(rng[i], 1'b1);
        drain;
        $display("tied done");
        send_word(8'hff);
        ctl.clear_reg(1'b0);
        cmp(parallel_out_o, 8'h00);
        ctl.clear_reg(1'b1);
        shadow = 8'h00;
        cmp({7'h00, cascade_serial_out_o}, 8'h00);
        ctl.store();
        loaded(8'h00);
        drain;
        $display("clears done");
        // one load more than the fifo holds, consumer stalled
        for (int n = 0; n < 33; n++) begin
            rng = xs(rng);
            send(rng[0], 1'b0);
            ctl.store();
            loaded(shadow);
        end
        cmp({1'b0, capture_ready_o, fifo_level_o}, 8'h20);
        cmp({7'h00, word_lost_o}, 8'h01);
        ctl.clear_reg(1'b0);
        cmp({7'h00, word_lost_o}, 8'h00);
        drain;
        $display("fill done");
        // a full pin frame while frozen must leave every register alone
        clk_en_i = 1'b0;
        ctl.shift_bit(1'b1, 1'b1);
        clk_en_i = 1'b1;
        ctl.hold(6);
        cmp(parallel_out_o, 8'h00);
        cmp({7'h00, cascade_serial_out_o}, {7'h00, shadow[7]});
        cmp({2'h0, fifo_level_o}, 8'h00);
        $display("enable done");
        print_verdict;
    end
endmodule // serial_in_parallel_out_latch_bench

// [verif/sipo_controller.sv]
`timescale 1ns/100ps
// ****
// controller model on the pin side
// ****
module sipo_controller (
    input wire clk_i,
    output logic data_o,
    output logic sh_clk_o,
    output logic sh_clr_n_o,
    output logic st_clk_o,
    output logic st_clr_n_o
);
    initial begin
        {data_o, sh_clk_o, st_clk_o, sh_clr_n_o, st_clr_n_o} = 5'h03;
    end
    task automatic hold(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    // four cycles per level, two above what the pin filter needs
    task automatic shift_bit(input logic b, input logic tie);
        data_o = b;
        hold(4);
        {sh_clk_o, st_clk_o} = {1'b1, tie};
        hold(4);
        {sh_clk_o, st_clk_o} = 2'h0;
        data_o = ~b; // hold time over, stale bit must not be trusted
        hold(4);
    endtask
    task automatic store;
        st_clk_o = 1'b1;
        hold(4);
        st_clk_o = 1'b0;
        hold(4);
    endtask
    task automatic clear_reg(input logic sh);
        {sh_clr_n_o, st_clr_n_o} = {!sh, sh};
        hold(4);
        sh_clk_o = sh; // a shift edge under shift clear when sh is 1; no edge when sh is 0
        hold(4);
        {sh_clk_o, sh_clr_n_o, st_clr_n_o} = 3'h3;
        hold(6);
    endtask
endmodule // sipo_controller

// [verif/sipo_latch_chk.sv]
`timescale 1ns/100ps
// ****
// port checks; pins act three cycles late
// ****
module sipo_latch_chk #(
    parameter WIDTH = 8,
    parameter FIFO_AW = 5
) (
    input wire clk_i,
    input wire resetn_i,
    input wire clk_en_i,
    input wire shift_clock_i,
    input wire shift_clear_n_i,
    input wire storage_clock_i,
    input wire storage_clear_n_i,
    input wire word_ready_i,
    input wire [WIDTH-1:0] parallel_out_o,
    input wire cascade_serial_out_o,
    input wire word_valid_o,
    input wire capture_ready_o,
    input wire word_lost_o,
    input wire [FIFO_AW:0] fifo_level_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    sequence s_st_rise;
        !storage_clock_i ##1 (storage_clock_i && clk_en_i);
    endsequence
    // five-sample windows leave room for the pin filter
    sequence s_calm(room);
        (clk_en_i && storage_clear_n_i && !word_ready_i
            && capture_ready_o == room)[*5];
    endsequence
    AST_SHIFT_CLEAR: assert property (
        !shift_clear_n_i [*6] |-> !cascade_serial_out_o)
        else $error("shift clear ignored");
    AST_STORE_CLEAR: assert property (
        !storage_clear_n_i [*6] |-> parallel_out_o == '0)
        else $error("storage clear ignored");
    AST_SHIFT_HOLD: assert property (
        (shift_clear_n_i && !shift_clock_i) [*6]
        |-> $stable(cascade_serial_out_o)) else $error("shift moved");
    AST_STORE_HOLD: assert property (
        (storage_clear_n_i && !storage_clock_i) [*6]
        |-> $stable(parallel_out_o)) else $error("storage moved");
    AST_STORE_LOAD: assert property (
        s_st_rise ##0 s_calm(1'b1)
        |-> fifo_level_o == $past(fifo_level_o, 4) + 1'b1)
        else $error("load not queued");
    AST_STORE_LOST: assert property (
        s_st_rise ##0 s_calm(1'b0) |-> word_lost_o)
        else $error("lost load not flagged");
    AST_VALID_LEVEL: assert property (
        word_valid_o == (fifo_level_o != '0)) else $error("valid wrong");
    AST_POP_LEVEL: assert property (
        clk_en_i && word_valid_o && word_ready_i
        && !$past(storage_clock_i, 3)
        |=> fifo_level_o == $past(fifo_level_o) - 1'b1)
        else $error("pop not counted");
endmodule // sipo_latch_chk

bind serial_in_parallel_out_latch sipo_latch_chk #(
    .WIDTH(WIDTH), .FIFO_AW(FIFO_AW)) chk (
    .clk_i, .resetn_i, .clk_en_i, .shift_clock_i, .shift_clear_n_i,
    .storage_clock_i,
    .storage_clear_n_i, .word_ready_i, .parallel_out_o,
    .cascade_serial_out_o, .word_valid_o, .capture_ready_o, .word_lost_o,
    .fifo_level_o);
